// >>> bench/ecasmf_line_model.sv
// model of the incoming e1 line: one timeslot 16 sample per frame
`timescale 1ns/100ps
module ecasmf_line_model (
   input  wire logic       clk_in,
   input  wire logic       send_in,
   input  wire logic [3:0] bits_in,
   output logic            valid_out,
   output logic      [3:0] bits_out
);
   initial begin
      valid_out = 1'b0;
      bits_out  = 4'h0;
   end
   // between frames the bits flip so stale data is never mistaken for a sample
   always @(posedge clk_in) begin
      valid_out <= send_in;
      bits_out  <= send_in ? bits_in : ~bits_out;
   end
endmodule

// >>> bench/test_ecasmf_align.sv
// self-checking bench for the cas multiframe alignment selector
`timescale 1ns/100ps
module test_ecasmf_align;
   logic        clk = 0, rstn = 0, wr = 0, rd = 0, send = 0, fa = 1, lset = 0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00, rdata;
   logic [3:0]  bits = 4'h0, tsb;
   logic        tsv, align, loss, decl;
   int          fail_count = 0, n_checks = 0, n_decl = 0;
   // =====================================================
   // clock, line model and device
   always #50 clk = ~clk;
   always @(posedge clk) if (decl === 1'b1) n_decl <= n_decl + 1;
   ecasmf_line_model line (.clk_in(clk), .send_in(send), .bits_in(bits),
      .valid_out(tsv), .bits_out(tsb));
   ecasmf_align dut (.CLK_IN(clk), .RESETN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .TS16_VALID_IN(tsv), .TS16_BITS_IN(tsb),
      .FRAME_ALIGNED_IN(fa), .LOSS_SET_IN(lset), .MF_ALIGN_OUT(align),
      .LOSS_CAS_MF_OUT(loss), .DECLARE_OUT(decl));
   // =====================================================
   // bus, line and compare helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // fa is held until the device has sampled the frame
   task automatic frame(input logic [3:0] b, input logic f);
      @(posedge clk);
      send <= 1'b1;
      bits <= b;
      fa <= f;
      @(posedge clk);
      send <= 1'b0;
      @(posedge clk);
      fa <= 1'b1;
   endtask
   // drop alignment, select, feed a miss run then one hit, judge the outcome
   task automatic try(input logic [1:0] s, input int n, input logic mf, input logic e);
      int d0;
      @(posedge clk);
      lset <= 1'b1;
      @(posedge clk);
      lset <= 1'b0;
      wr_reg(ecasmf_pkg::FRAMING_SELECTION_ADDR, {2'h0, s, 4'h0});
      d0 = n_decl;
      for (int i = 0; i < n; i++) frame(4'((i % 15) + 1), mf);
      frame(ecasmf_pkg::PATTERN, 1'b1);
      repeat (2) @(posedge clk);
      #1 chk({6'h0, align, loss}, {6'h0, e, !e});
      chk(8'(n_decl - d0), {7'h0, e});
   endtask
   // leaving the enabled codes drops a declared alignment
   task automatic t_drop;
      wr_reg(ecasmf_pkg::FRAMING_SELECTION_ADDR, 8'h00);
      rd_reg(ecasmf_pkg::ALIGN_STATUS_ADDR, 8'h02);
   endtask
   task automatic t_regs;
      rd_reg(ecasmf_pkg::FRAMING_SELECTION_ADDR, 8'h00);
      rd_reg(ecasmf_pkg::ALIGN_STATUS_ADDR, 8'h02);
      wr_reg(ecasmf_pkg::FRAMING_SELECTION_ADDR, 8'h30);
      rd_reg(ecasmf_pkg::FRAMING_SELECTION_ADDR, 8'h30);
      rd_reg(16'h0109, 8'h00);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      try(2'h0, 1, 1'b1, 1'b0);
      try(2'h3, 1, 1'b1, 1'b0);
      try(2'h2, 1, 1'b1, 1'b1);
      rd_reg(ecasmf_pkg::ALIGN_STATUS_ADDR, 8'h01);
      t_drop();
      try(2'h1, 14, 1'b1, 1'b0);
      try(2'h1, 15, 1'b1, 1'b1);
      try(2'h1, 16, 1'b1, 1'b0);
      try(2'h2, 1, 1'b0, 1'b0);
      complete_run();
   end
endmodule

// >>> hw/ecasmf_align.sv
// cas multiframe alignment declaration with its framing selection register
//
// How it works
// R01 - two-bit rw select, bits 5:4, reset 00
// R02 - select 00 or 11 disables declaration
// R03 - examine timeslot 16 bits 1-4 each frame
// R04 - select 01: 15 misses then hit declares
// R05 - select 10: one miss then hit declares
// R06 - pattern is all zero, only while framed
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module ecasmf_align (
   input  wire logic        CLK_IN,
   input  wire logic        RESETN_IN,
   input  wire logic [15:0] ADDR_IN,
   input  wire logic [7:0]  WDATA_IN,
   input  wire logic        WR_IN,
   input  wire logic        RD_IN,
   output logic      [7:0]  RDATA_OUT,
   input  wire logic        TS16_VALID_IN,
   input  wire logic [3:0]  TS16_BITS_IN,
   input  wire logic        FRAME_ALIGNED_IN,
   input  wire logic        LOSS_SET_IN,
   output logic             MF_ALIGN_OUT,
   output logic             LOSS_CAS_MF_OUT,
   output logic             DECLARE_OUT
);
   // =====================================================
   // register file
   logic [7:0] framing_selection_q;
   logic [1:0] sel;
   logic       enabled;
   assign sel     = framing_selection_q[ecasmf_pkg::SEL_MSB:ecasmf_pkg::SEL_LSB];
   assign enabled = (sel == ecasmf_pkg::SEL_16FR) || (sel == ecasmf_pkg::SEL_2FR);  // R02

   // the whole byte is kept so other fields read back as written
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         framing_selection_q <= ecasmf_pkg::FRAMING_SELECTION_RST;  // R01
      end else if (WR_IN && ADDR_IN == ecasmf_pkg::FRAMING_SELECTION_ADDR) begin
         framing_selection_q <= WDATA_IN;  // R01
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         RDATA_OUT <= 8'h00;
      end else if (RD_IN) begin
         case (ADDR_IN)
            ecasmf_pkg::FRAMING_SELECTION_ADDR: RDATA_OUT <= framing_selection_q;
            ecasmf_pkg::ALIGN_STATUS_ADDR:
               RDATA_OUT <= {6'h00, LOSS_CAS_MF_OUT, MF_ALIGN_OUT};
            default:                            RDATA_OUT <= 8'h00;
         endcase
      end else begin
         RDATA_OUT <= 8'h00;
      end
   end

   // =====================================================
   // pattern tracking
   // the run counter is one bit wider than the largest need so that a run
   // longer than fifteen misses can be told apart from exactly fifteen
   localparam int                  MISS_W    = 5;
   localparam logic [MISS_W-1:0]   MISS_ZERO = 5'h00;
   localparam logic [MISS_W-1:0]   MISS_ONE  = 5'h01;
   localparam logic [MISS_W-1:0]   MISS_SAT  = 5'h10;  // one past the largest need

   logic              hit;
   logic              eval;
   logic              unframed;
   logic [MISS_W-1:0] miss_q;
   logic [MISS_W-1:0] need;
   logic              declare;

   // a sample only counts while the select is on and basic framing holds
   assign eval     = TS16_VALID_IN && FRAME_ALIGNED_IN && enabled;  // R03 R06
   assign unframed = TS16_VALID_IN && !FRAME_ALIGNED_IN;  // R06
   assign hit      = (TS16_BITS_IN == ecasmf_pkg::PATTERN);  // R06
   assign need     = (sel == ecasmf_pkg::SEL_16FR) ? {1'b0, ecasmf_pkg::MISS_16FR}
                                                   : {1'b0, ecasmf_pkg::MISS_2FR};
   // run of misses must end exactly at the needed count, not above it
   assign declare  = eval && hit && (miss_q == need);  // R04 R05

   // consecutive miss counter saturates one past the largest need;
   // a frame seen without basic framing breaks the run, since the
   // timeslot position it came from cannot be trusted
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         miss_q <= MISS_ZERO;
      end else if (!enabled || unframed) begin
         miss_q <= MISS_ZERO;  // R02 R06
      end else if (eval) begin
         if (hit) begin
            miss_q <= MISS_ZERO;  // R04 R05
         end else if (miss_q != MISS_SAT) begin
            miss_q <= miss_q + MISS_ONE;  // R04 R05
         end
      end
   end

   // alignment state; declaring wins over a concurrent loss
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         MF_ALIGN_OUT    <= 1'b0;
         LOSS_CAS_MF_OUT <= 1'b1;
         DECLARE_OUT     <= 1'b0;
      end else begin
         DECLARE_OUT <= declare;
         if (declare) begin
            MF_ALIGN_OUT    <= 1'b1;  // R04 R05
            LOSS_CAS_MF_OUT <= 1'b0;  // R04 R05
         end else if (LOSS_SET_IN || !enabled) begin
            MF_ALIGN_OUT    <= 1'b0;
            LOSS_CAS_MF_OUT <= 1'b1;
         end
      end
   end

   // =====================================================
   // checks
   property p_disabled_quiet;
      @(posedge CLK_IN) disable iff (!RESETN_IN) !enabled |=> !DECLARE_OUT;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("declare while off"); // R02

   property p_declare_clears;
      @(posedge CLK_IN) disable iff (!RESETN_IN) DECLARE_OUT |-> !LOSS_CAS_MF_OUT && MF_ALIGN_OUT;
   endproperty
   a_declare_clears: assert property (p_declare_clears) else $error("loss not cleared"); // R04

   property p_declare_needs_hit;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         DECLARE_OUT |-> $past(TS16_BITS_IN) == ecasmf_pkg::PATTERN && $past(FRAME_ALIGNED_IN);
   endproperty
   a_declare_needs_hit: assert property (p_declare_needs_hit) else $error("bad hit"); // R06

   property p_2fr;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         (sel == ecasmf_pkg::SEL_2FR) && declare |-> miss_q == {1'b0, ecasmf_pkg::MISS_2FR};
   endproperty
   a_2fr: assert property (p_2fr) else $error("2-frame count wrong"); // R05

   property p_16fr;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         (sel == ecasmf_pkg::SEL_16FR) && declare |-> miss_q == {1'b0, ecasmf_pkg::MISS_16FR};
   endproperty
   a_16fr: assert property (p_16fr) else $error("16-frame count wrong"); // R04

   property p_sel_reset;
      @(posedge CLK_IN) $rose(RESETN_IN) |-> sel == ecasmf_pkg::SEL_OFF_LO;
   endproperty
   a_sel_reset: assert property (p_sel_reset) else $error("select not reset"); // R01

   property p_write_sel;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         WR_IN && ADDR_IN == ecasmf_pkg::FRAMING_SELECTION_ADDR
            |=> sel == $past(WDATA_IN[ecasmf_pkg::SEL_MSB:ecasmf_pkg::SEL_LSB]);
   endproperty
   a_write_sel: assert property (p_write_sel) else $error("select write lost"); // R01

   property p_no_eval_unframed;
      @(posedge CLK_IN) disable iff (!RESETN_IN) !FRAME_ALIGNED_IN |=> !DECLARE_OUT;
   endproperty
   a_no_eval_unframed: assert property (p_no_eval_unframed) else $error("unframed declare"); // R03

   c_16: cover property (@(posedge CLK_IN) declare && sel == ecasmf_pkg::SEL_16FR);
   c_2:  cover property (@(posedge CLK_IN) declare && sel == ecasmf_pkg::SEL_2FR);
   c_off: cover property (@(posedge CLK_IN) sel == ecasmf_pkg::SEL_OFF_HI && TS16_VALID_IN);
   // a declare racing an outside loss report, and a run too long to declare
   c_race: cover property (@(posedge CLK_IN) declare && LOSS_SET_IN);
   c_long: cover property (@(posedge CLK_IN) eval && hit && miss_q == MISS_SAT);

   // =====================================================
   // checks on the declare pulse and the alignment state

   // a hit always clears the run, so two declares can never touch
   property p_declare_single;
      @(posedge CLK_IN) disable iff (!RESETN_IN) DECLARE_OUT |=> !DECLARE_OUT;
   endproperty
   a_declare_single: assert property (p_declare_single) else $error("declare too long"); // R04

   // once declared, alignment stands until loss is reported or the select is off
   property p_align_holds;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         MF_ALIGN_OUT && enabled && !LOSS_SET_IN |=> MF_ALIGN_OUT;
   endproperty
   a_align_holds: assert property (p_align_holds) else $error("alignment dropped"); // R04

   // an outside loss report drops alignment when no declare competes
   property p_loss_set;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         LOSS_SET_IN && !declare |=> LOSS_CAS_MF_OUT && !MF_ALIGN_OUT;
   endproperty
   a_loss_set: assert property (p_loss_set) else $error("loss report lost"); // R04

   // the fresh declare wins over a loss report in the same cycle
   property p_declare_wins;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         LOSS_SET_IN && declare |=> MF_ALIGN_OUT && !LOSS_CAS_MF_OUT;
   endproperty
   a_declare_wins: assert property (p_declare_wins) else $error("declare lost race"); // R05

   // leaving the enabled codes drops alignment and sets the defect
   property p_disable_drops;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         !enabled |=> !MF_ALIGN_OUT && LOSS_CAS_MF_OUT;
   endproperty
   a_disable_drops: assert property (p_disable_drops) else $error("aligned while off"); // R02

   // a declare must come from a real sample taken while enabled
   property p_declare_needs_sample;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         DECLARE_OUT |-> $past(TS16_VALID_IN) && $past(enabled);
   endproperty
   a_declare_needs_sample: assert property (p_declare_needs_sample) else $error("no sample"); // R03

   // a hit after a run of the wrong length must stay quiet
   property p_wrong_count_quiet;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         eval && hit && miss_q != need |=> !DECLARE_OUT;
   endproperty
   a_wrong_count_quiet: assert property (p_wrong_count_quiet) else $error("bad run declared"); // R04

   // =====================================================
   // checks on the miss run counter

   // every hit ends the run
   property p_hit_clears_run;
      @(posedge CLK_IN) disable iff (!RESETN_IN) eval && hit |=> miss_q == MISS_ZERO;
   endproperty
   a_hit_clears_run: assert property (p_hit_clears_run) else $error("run not cleared"); // R06

   // every framed miss adds one until the counter saturates
   property p_miss_counts;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         eval && !hit && miss_q != MISS_SAT |=> miss_q == $past(miss_q) + MISS_ONE;
   endproperty
   a_miss_counts: assert property (p_miss_counts) else $error("miss not counted"); // R04

   // a saturated run never wraps back into a declarable count
   property p_run_saturates;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         eval && !hit && miss_q == MISS_SAT |=> miss_q == MISS_SAT;
   endproperty
   a_run_saturates: assert property (p_run_saturates) else $error("run wrapped"); // R04

   // a sample without basic framing restarts the run
   property p_unframed_clears;
      @(posedge CLK_IN) disable iff (!RESETN_IN) unframed |=> miss_q == MISS_ZERO;
   endproperty
   a_unframed_clears: assert property (p_unframed_clears) else $error("unframed counted"); // R06

   // between samples the run is left alone while the select is on
   property p_idle_holds_run;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         enabled && !TS16_VALID_IN |=> miss_q == $past(miss_q);
   endproperty
   a_idle_holds_run: assert property (p_idle_holds_run) else $error("run moved idle"); // R03

   // =====================================================
   // checks on the register port

   // read data stand only in the cycle after a read strobe
   property p_rdata_idle;
      @(posedge CLK_IN) disable iff (!RESETN_IN) !RD_IN |=> RDATA_OUT == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("stale read data"); // R01

   // the select register reads back as held
   property p_rdata_select;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         RD_IN && ADDR_IN == ecasmf_pkg::FRAMING_SELECTION_ADDR
            |=> RDATA_OUT == $past(framing_selection_q);
   endproperty
   a_rdata_select: assert property (p_rdata_select) else $error("select readback"); // R01

   // status shows the alignment state of the read cycle
   property p_rdata_status;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
         RD_IN && ADDR_IN == ecasmf_pkg::ALIGN_STATUS_ADDR
            |=> RDATA_OUT[ecasmf_pkg::ST_ALIGN] == $past(MF_ALIGN_OUT)
                && RDATA_OUT[ecasmf_pkg::ST_LOSS] == $past(LOSS_CAS_MF_OUT);
   endproperty
   a_rdata_status: assert property (p_rdata_status) else $error("status readback"); // R04

   // =====================================================
   // limitations for users of this block
   // - only one channel is handled; a multi-channel framer instantiates one
   //   copy per channel, each fed from its own recovered frame timing
   // - the loss criteria live outside; they arrive on the loss input only
   // - a run of misses longer than fifteen never declares, so a line that
   //   skips a pattern must first show a clean sixteen-frame cycle
   // - a change of select is taken at once; a run begun under one code
   //   carries over to the other enabled code, which a user should avoid
   //   by writing the off code between two enabled codes
endmodule

// >>> hw/ecasmf_pkg.sv
// package of constants for the e1 cas multiframe alignment selector
package ecasmf_pkg;
   // =====================================================
   // register map
   localparam logic [15:0] FRAMING_SELECTION_ADDR = 16'h0107;
   localparam logic [15:0] ALIGN_STATUS_ADDR      = 16'h0108;
   localparam logic [7:0]  FRAMING_SELECTION_RST  = 8'h00;
   localparam int          SEL_LSB                = 4;
   localparam int          SEL_MSB                = 5;
   // =====================================================
   // algorithm select encodings
   localparam logic [1:0]  SEL_OFF_LO = 2'h0;
   localparam logic [1:0]  SEL_16FR   = 2'h1;
   localparam logic [1:0]  SEL_2FR    = 2'h2;
   localparam logic [1:0]  SEL_OFF_HI = 2'h3;
   // =====================================================
   // frame counts
   localparam logic [3:0]  MISS_16FR  = 4'hf;  // 15 frames without pattern
   localparam logic [3:0]  MISS_2FR   = 4'h1;  // 1 frame without pattern
   localparam logic [3:0]  PATTERN    = 4'h0;  // ts16 bits 1-4 all zero
   // =====================================================
   // status bit positions
   localparam int          ST_ALIGN   = 0;
   localparam int          ST_LOSS    = 1;
endpackage
